/* File: pfs_pad_mux.sv */
// pfs_pad_mux: one shared pad steered between gpio and two alternates.
// assumes pad_in comes from a pin and code from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
module pfs_pad_mux
	import pfs_pkg::*;
(
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	// selection
	input  wire pfs_func_type code,
	// pad side
	input  wire logic         pad_in,
	output logic              pad_out,
	output logic              pad_oe_n,
	// function side
	input  wire logic         gpio_out,
	input  wire logic         gpio_oe_n,
	input  wire logic         alt1_out,
	input  wire logic         alt1_oe_n,
	input  wire logic         alt2_out,
	input  wire logic         alt2_oe_n,
	output logic              gpio_in,
	output logic              alt1_in,
	output logic              alt2_in
);

	logic meta_r;
	logic sync_r;
	logic out_nxt;
	logic oe_n_nxt;

	// unselected functions see zero on their input, never a stale pad
	assign out_nxt  = (code == PFS_FN_ALT1) ? alt1_out :
	                  (code == PFS_FN_ALT2) ? alt2_out : gpio_out;
	assign oe_n_nxt = (code == PFS_FN_ALT1) ? alt1_oe_n :
	                  (code == PFS_FN_ALT2) ? alt2_oe_n : gpio_oe_n;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r   <= 1'b0;
			sync_r   <= 1'b0;
			pad_out  <= 1'b0;
			pad_oe_n <= 1'b1;
			gpio_in  <= 1'b0;
			alt1_in  <= 1'b0;
			alt2_in  <= 1'b0;
		end else if (ce) begin
			meta_r   <= pad_in;
			sync_r   <= meta_r;
			pad_out  <= out_nxt;
			pad_oe_n <= oe_n_nxt;
			gpio_in  <= (code == PFS_FN_GPIO) & sync_r;
			alt1_in  <= (code == PFS_FN_ALT1) & sync_r;
			alt2_in  <= (code == PFS_FN_ALT2) & sync_r;
		end
	end

endmodule
`default_nettype wire

/* File: pfs_pkg.sv */
// pfs_pkg: offsets, field positions, pad index map and reset values
// for the pad function and pull select block.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
package pfs_pkg;

	typedef enum logic [1:0] {PFS_FN_GPIO, PFS_FN_ALT1, PFS_FN_ALT2} pfs_func_type;

	localparam int          PFS_NPAD      = 52;
	localparam int          PFS_NPULL     = 64;
	localparam int          PFS_AW        = 8;

	localparam logic [7:0]  PFS_OFS_MUX   = 8'h24;
	localparam logic [7:0]  PFS_OFS_P0AB  = 8'h28;
	localparam logic [7:0]  PFS_OFS_P0CD  = 8'h2c;
	localparam logic [7:0]  PFS_OFS_P1AB  = 8'h30;
	localparam logic [7:0]  PFS_OFS_P1CD  = 8'h34;

	localparam logic [31:0] PFS_RST_MUX   = 32'h0000_0000;
	localparam logic [31:0] PFS_RST_PULL  = 32'h0000_0000;
	localparam logic [31:0] PFS_MUX_WMASK = 32'h007f_ffff;

	localparam logic [1:0]  PFS_RESP_OK   = 2'h0;
	localparam logic [1:0]  PFS_RESP_ERR  = 2'h2;

	localparam logic [1:0]  PFS_PULL_UP   = 2'h1;
	localparam logic [1:0]  PFS_PULL_DN   = 2'h2;

	// select bit positions in the mux register
	localparam int B_VIPCLK   = 0;
	localparam int B_I2S      = 1;
	localparam int B_VIP2     = 2;
	localparam int B_VIP3     = 3;
	localparam int B_HOST     = 4;
	localparam int B_LRCK     = 5;
	localparam int B_VSYNC    = 6;
	localparam int B_DEN      = 7;
	localparam int B_LCD18    = 8;
	localparam int B_LCD24    = 9;
	localparam int B_LCD16    = 10;
	localparam int B_PWM0     = 11;
	localparam int B_U0CTS    = 12;
	localparam int B_U0RTS    = 13;
	localparam int B_PWM3_LO  = 14;
	localparam int B_FCS1     = 16;
	localparam int B_FCS2     = 17;
	localparam int B_FCS3     = 18;
	localparam int B_TS       = 19;
	localparam int B_GPS_LO   = 20;
	localparam int B_VIP0     = 22;

	// pad index map
	localparam int P_P0D      = 0;
	localparam int P_P0C2     = 8;
	localparam int P_P0C0     = 14;
	localparam int P_P2HOST   = 16;
	localparam int P_P2I2S    = 30;
	localparam int P_ADC      = 35;
	localparam int P_VIP0     = 37;
	localparam int P_GPS      = 38;
	localparam int P_FCS1     = 39;
	localparam int P_FCS2     = 40;
	localparam int P_FCS3     = 41;
	localparam int P_PWM3     = 42;
	localparam int P_U0RTS    = 43;
	localparam int P_U0CTS    = 44;
	localparam int P_PWM0     = 45;
	localparam int P_DEN      = 46;
	localparam int P_VSYNC    = 47;
	localparam int P_LRCK     = 48;
	localparam int P_VIP3     = 49;
	localparam int P_VIP2     = 50;
	localparam int P_VIPCLK   = 51;

endpackage

/* File: pfs_top.sv */
// pfs_top: pad function multiplexer and pull control behind AXI4-Lite.
// assumes one clock, synchronous reset, pads buffered outside.
//
// What this block does
// [RULE1] bit 10: port0 D pads to lcd data 8-15
// [RULE2] bit 9: port0 C2-C7 to lcd data 18-23
// [RULE3] bit 8: port0 C0-C1 to lcd data 16-17
// [RULE4] bit 4: port2 lines 0-13 to host port
// [RULE5] bit 1 inverted: zero gives i2s pads
// [RULE6] bit 19: adc I[9:8] or stream flags
// [RULE7] 0x28 pulls port0 A0-B7, two bits each
// [RULE8] 0x2c pulls port0 C0-D7, D0 at 16
// [RULE9] 0x30 pulls port1 A0-B7, B7 on top
// [RULE10] 0x34 pulls port1 C0-D7, resets to zero
// [RULE11] single select bits: zero gpio, one alternate
// [RULE12] two-bit selects: 00 gpio, 01 first, 10 second
// [RULE13] after reset every pad is gpio input; the code leaves pads 30-36 on their first alternate
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pfs_top
	import pfs_pkg::*;
(
	// clock, reset, enable
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 ce,
	// axi4-lite write address
	input  wire logic [PFS_AW-1:0]    s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [PFS_AW-1:0]    s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// axi4-lite read data
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// shared pads
	input  wire logic [PFS_NPAD-1:0]  pad_in,
	output logic [PFS_NPAD-1:0]       pad_out,
	output logic [PFS_NPAD-1:0]       pad_oe_n,
	// gpio function per pad
	input  wire logic [PFS_NPAD-1:0]  gpio_out,
	input  wire logic [PFS_NPAD-1:0]  gpio_oe_n,
	output logic [PFS_NPAD-1:0]       gpio_in,
	// first alternate per pad
	input  wire logic [PFS_NPAD-1:0]  alt1_out,
	input  wire logic [PFS_NPAD-1:0]  alt1_oe_n,
	output logic [PFS_NPAD-1:0]       alt1_in,
	// second alternate per pad
	input  wire logic [PFS_NPAD-1:0]  alt2_out,
	input  wire logic [PFS_NPAD-1:0]  alt2_oe_n,
	output logic [PFS_NPAD-1:0]       alt2_in,
	// pull controls, port0 A0..D7 then port1 A0..D7
	output logic [PFS_NPULL-1:0]      pull_up_en,
	output logic [PFS_NPULL-1:0]      pull_down_en
);

	// register state
	logic [31:0]       mux_r;
	logic [31:0]       pull_r [4];
	logic [31:0]       mux_nxt;
	logic [31:0]       pull_nxt [4];

	// write channel state
	logic              aw_held_r;
	logic              w_held_r;
	logic [PFS_AW-1:0] awaddr_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;

	// read channel state
	logic [31:0]       rdata_nxt;
	logic [1:0]        rresp_nxt;

	// decode wires
	logic              wr_fire;
	logic [PFS_AW-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic [31:0]       wr_mask;
	logic              wr_mux;
	logic [3:0]        wr_pull;
	logic              wr_hit;
	logic              rd_fire;
	logic              rd_mux;
	logic [3:0]        rd_pull;
	logic              rd_hit;

	// per-pad function codes
	pfs_func_type      code [PFS_NPAD];

	// write address and data may arrive in either order; each is held
	// until its partner shows, then the write and response happen together
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;

	assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
	assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
	assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
	assign wr_fire = ce && !s_axi_bvalid
	               && (aw_held_r || s_axi_awvalid)
	               && (w_held_r || s_axi_wvalid);

	assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
	                  {8{wr_strb[1]}}, {8{wr_strb[0]}}};

	assign wr_mux     = wr_addr == PFS_OFS_MUX;
	assign wr_pull[0] = wr_addr == PFS_OFS_P0AB;
	assign wr_pull[1] = wr_addr == PFS_OFS_P0CD;
	assign wr_pull[2] = wr_addr == PFS_OFS_P1AB;
	assign wr_pull[3] = wr_addr == PFS_OFS_P1CD;
	assign wr_hit     = wr_mux || (|wr_pull);

	// upper mux bits belong to another block: they read back as zero
	assign mux_nxt = (mux_r & ~(wr_mask & PFS_MUX_WMASK))
	               | (wr_data & wr_mask & PFS_MUX_WMASK);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pull_nxt
			assign pull_nxt[g] = (pull_r[g] & ~wr_mask) | (wr_data & wr_mask);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
		end else if (ce) begin
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held_r <= 1'b1;
					awaddr_r  <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held_r <= 1'b1;
					wdata_r  <= s_axi_wdata;
					wstrb_r  <= s_axi_wstrb;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= PFS_RESP_OK;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? PFS_RESP_OK : PFS_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// everything resets to zero, so all pads but 30-36 start as gpio inputs; those start on their first alternate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mux_r <= PFS_RST_MUX; // see [RULE13]
		end else if (ce && wr_fire && wr_mux) begin
			mux_r <= mux_nxt;
		end
	end

	generate
		for (g = 0; g < 4; g++) begin : g_pull_reg
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pull_r[g] <= PFS_RST_PULL; // see [RULE10]
				end else if (ce && wr_fire && wr_pull[g]) begin
					pull_r[g] <= pull_nxt[g];
				end
			end
		end
	endgenerate

	// reads: one outstanding, data registered
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = ce && s_axi_arvalid && s_axi_arready;

	assign rd_mux     = s_axi_araddr == PFS_OFS_MUX;
	assign rd_pull[0] = s_axi_araddr == PFS_OFS_P0AB;
	assign rd_pull[1] = s_axi_araddr == PFS_OFS_P0CD;
	assign rd_pull[2] = s_axi_araddr == PFS_OFS_P1AB;
	assign rd_pull[3] = s_axi_araddr == PFS_OFS_P1CD;
	assign rd_hit     = rd_mux || (|rd_pull);

	assign rdata_nxt = rd_mux     ? (mux_r & PFS_MUX_WMASK) :
	                   rd_pull[0] ? pull_r[0] :
	                   rd_pull[1] ? pull_r[1] :
	                   rd_pull[2] ? pull_r[2] :
	                   rd_pull[3] ? pull_r[3] : 32'h0000_0000;
	assign rresp_nxt = rd_hit ? PFS_RESP_OK : PFS_RESP_ERR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= PFS_RESP_OK;
		end else if (ce) begin
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdata_nxt;
				s_axi_rresp  <= rresp_nxt;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// single select bit to a function code
	function automatic pfs_func_type sel1(input logic b);
		return b ? PFS_FN_ALT1 : PFS_FN_GPIO;
	endfunction

	// two-bit select field; the unlisted code 11 falls back to gpio
	function automatic pfs_func_type sel2(input logic [1:0] f);
		pfs_func_type c;
		c = PFS_FN_GPIO;
		unique case (f)
			2'h0: c = PFS_FN_GPIO;
			2'h1: c = PFS_FN_ALT1;
			2'h2: c = PFS_FN_ALT2;
			default: c = PFS_FN_GPIO;
		endcase
		return c;
	endfunction

	// pad index to function code; groups share one select bit
	function automatic pfs_func_type pad_code(input int i, input logic [31:0] m);
		pfs_func_type c;
		c = PFS_FN_GPIO;
		if (i < P_P0C2) begin
			c = sel1(m[B_LCD16]); // see [RULE1]
		end else if (i < P_P0C0) begin
			c = sel1(m[B_LCD24]); // see [RULE2]
		end else if (i < P_P2HOST) begin
			c = sel1(m[B_LCD18]); // see [RULE3]
		end else if (i < P_P2I2S) begin
			c = sel1(m[B_HOST]); // see [RULE4]
		end else if (i < P_ADC) begin
			c = sel1(!m[B_I2S]); // see [RULE5]
		end else if (i < P_VIP0) begin
			// these two pads have no gpio: adc data or stream flags
			c = m[B_TS] ? PFS_FN_ALT2 : PFS_FN_ALT1; // see [RULE6]
		end else if (i == P_GPS) begin
			c = sel2(m[B_GPS_LO+:2]); // see [RULE12]
		end else if (i == P_PWM3) begin
			c = sel2(m[B_PWM3_LO+:2]); // see [RULE12]
		end else begin
			unique case (i)
				P_VIP0:   c = sel1(m[B_VIP0]); // see [RULE11]
				P_FCS1:   c = sel1(m[B_FCS1]);
				P_FCS2:   c = sel1(m[B_FCS2]);
				P_FCS3:   c = sel1(m[B_FCS3]);
				P_U0RTS:  c = sel1(m[B_U0RTS]);
				P_U0CTS:  c = sel1(m[B_U0CTS]);
				P_PWM0:   c = sel1(m[B_PWM0]);
				P_DEN:    c = sel1(m[B_DEN]);
				P_VSYNC:  c = sel1(m[B_VSYNC]);
				P_LRCK:   c = sel1(m[B_LRCK]);
				P_VIP3:   c = sel1(m[B_VIP3]);
				P_VIP2:   c = sel1(m[B_VIP2]);
				P_VIPCLK: c = sel1(m[B_VIPCLK]);
				default:  c = PFS_FN_GPIO;
			endcase
		end
		return c;
	endfunction

	// one mux per pad; the pad path is registered, so a select change
	// reaches the pin one cycle after the register write
	generate
		for (g = 0; g < PFS_NPAD; g++) begin : g_pad
			assign code[g] = pad_code(g, mux_r);
			pfs_pad_mux u_mux (
				.aclk      (aclk),
				.aresetn   (aresetn),
				.ce        (ce),
				.code      (code[g]),
				.pad_in    (pad_in[g]),
				.pad_out   (pad_out[g]),
				.pad_oe_n  (pad_oe_n[g]),
				.gpio_out  (gpio_out[g]),
				.gpio_oe_n (gpio_oe_n[g]),
				.alt1_out  (alt1_out[g]),
				.alt1_oe_n (alt1_oe_n[g]),
				.alt2_out  (alt2_out[g]),
				.alt2_oe_n (alt2_oe_n[g]),
				.gpio_in   (gpio_in[g]),
				.alt1_in   (alt1_in[g]),
				.alt2_in   (alt2_in[g])
			);
		end
	endgenerate

	// pull fields: 16 pads per register, pad k at bits 2k+1:2k;
	// reserved code 11 enables neither pull so the pad never fights itself
	generate
		for (g = 0; g < PFS_NPULL; g++) begin : g_pull
			logic [1:0] fld;
			assign fld = pull_r[g / 16][2 * (g % 16) +: 2]; // see [RULE7] [RULE8] [RULE9]
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pull_up_en[g]   <= 1'b0;
					pull_down_en[g] <= 1'b0;
				end else if (ce) begin
					pull_up_en[g]   <= fld == PFS_PULL_UP;
					pull_down_en[g] <= fld == PFS_PULL_DN;
				end
			end
		end
	endgenerate

	// prot bits carry no meaning here
	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule
`default_nettype wire

/* File: pfs_top_asserts.sv */
// pfs_top_chk: port-level checks on pad steering, pulls and the write bus.
// assumes it is bound into pfs_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pfs_top_chk
	import pfs_pkg::*;
(
	// clock and reset
	input wire logic					aclk,
	input wire logic					aresetn,
	input wire logic					ce,
	// write bus
	input wire logic [PFS_AW-1:0]		s_axi_awaddr,
	input wire logic					s_axi_awvalid,
	input wire logic					s_axi_awready,
	input wire logic [31:0]				s_axi_wdata,
	input wire logic [3:0]				s_axi_wstrb,
	input wire logic					s_axi_wvalid,
	input wire logic					s_axi_wready,
	input wire logic [1:0]				s_axi_bresp,
	input wire logic					s_axi_bvalid,
	input wire logic					s_axi_bready,
	// pads and functions
	input wire logic [PFS_NPAD-1:0]		pad_out,
	input wire logic [PFS_NPAD-1:0]		pad_oe_n,
	input wire logic [PFS_NPAD-1:0]		gpio_out,
	input wire logic [PFS_NPAD-1:0]		alt1_out,
	input wire logic [PFS_NPAD-1:0]		alt2_out,
	// pulls
	input wire logic [PFS_NPULL-1:0]	pull_up_en,
	input wire logic [PFS_NPULL-1:0]	pull_down_en
);
	// shadow of the mux register built from bus traffic, so no internal probes
	logic				ah_r, wh_r, vq_r;
	logic [PFS_AW-1:0]	aa_r;
	logic [31:0]		wd_r;
	logic [3:0]			ws_r;
	logic [22:0]		m_r;
	logic [51:0]		ex_r;
	logic [127:0]		pf_r;
	logic [63:0]		pu_r, pd_r;
	wire [63:0]			pu, pd;
	wire				aok = ah_r | (s_axi_awvalid & s_axi_awready);
	wire				wok = wh_r | (s_axi_wvalid & s_axi_wready);
	wire				tk = ce & aok & wok & ~s_axi_bvalid;
	wire [PFS_AW-1:0]	ta = ah_r ? aa_r : s_axi_awaddr;
	wire [31:0]			td = wh_r ? wd_r : s_axi_wdata;
	wire [3:0]			ts = wh_r ? ws_r : s_axi_wstrb;
	wire [31:0]			bm = {{8{ts[3]}}, {8{ts[2]}}, {8{ts[1]}}, {8{ts[0]}}};
	wire [51:0]			s1 = {m_r[0], m_r[2], m_r[3], m_r[5], m_r[6], m_r[7], m_r[11],
		m_r[12], m_r[13], m_r[15:14] == 2'b01, m_r[18], m_r[17], m_r[16],
		m_r[21:20] == 2'b01, m_r[22], {2{!m_r[19]}}, {5{!m_r[1]}}, {14{m_r[4]}},
		{2{m_r[8]}}, {6{m_r[9]}}, {8{m_r[10]}}};
	wire [51:0]			s2 = {9'h0, m_r[15:14] == 2'b10, 3'h0, m_r[21:20] == 2'b10,
		1'b0, {2{m_r[19]}}, 35'h0};
	wire [51:0]			ex = gpio_out & ~s1 & ~s2 | alt1_out & s1 | alt2_out & s2;

	// expected pull enables from the shadowed pull words, pad k at bits 2k+1:2k
	for (genvar k = 0; k < PFS_NPULL; k++) begin : g_pull_exp
		assign pu[k] = pf_r[2 * k +: 2] == PFS_PULL_UP;
		assign pd[k] = pf_r[2 * k +: 2] == PFS_PULL_DN;
	end

	always_ff @(posedge aclk) begin
		vq_r <= ce & aresetn;
		if (ce) begin
			ex_r <= ex;
			pu_r <= pu;
			pd_r <= pd;
		end
		if (!aresetn) begin
			ah_r <= 1'b0;
			wh_r <= 1'b0;
			m_r <= '0;
			pf_r <= '0;
		end else if (ce) begin
			ah_r <= aok & ~tk;
			wh_r <= wok & ~tk;
			aa_r <= ta;
			wd_r <= td;
			ws_r <= ts;
			if (tk && ta == PFS_OFS_MUX)
				m_r <= m_r & ~bm[22:0] | td[22:0] & bm[22:0];
			for (int k = 0; k < 4; k++) begin
				if (tk && ta == PFS_OFS_P0AB + 8'(4 * k))
					pf_r[32 * k +: 32] <= pf_r[32 * k +: 32] & ~bm | td & bm;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	lcd_mid_a: assert property (vq_r |-> pad_out[7:0] == ex_r[7:0])
		else $error("lcd mid byte pads wrong");
	lcd_top_a: assert property (vq_r |-> pad_out[13:8] == ex_r[13:8])
		else $error("lcd top six pads wrong");
	lcd_low_a: assert property (vq_r |-> pad_out[15:14] == ex_r[15:14])
		else $error("lcd bits 16 17 pads wrong");
	host_port_a: assert property (vq_r |-> pad_out[29:16] == ex_r[29:16])
		else $error("host port pads wrong");
	i2s_pads_a: assert property (vq_r |-> pad_out[34:30] == ex_r[34:30])
		else $error("audio pads wrong");
	adc_stream_a: assert property (vq_r |-> pad_out[36:35] == ex_r[36:35])
		else $error("adc or stream pads wrong");
	single_sel_a: assert property (vq_r |-> {pad_out[51:43], pad_out[41:39], pad_out[37]} == {ex_r[51:43], ex_r[41:39], ex_r[37]})
		else $error("single select pads wrong");
	two_bit_a: assert property (vq_r |-> {pad_out[42], pad_out[38]} == {ex_r[42], ex_r[38]})
		else $error("two bit select pads wrong");
	pull_excl_a: assert property (vq_r |-> pull_up_en == pu_r && pull_down_en == pd_r)
		else $error("pull enables wrong");
	reset_idle_a: assert property ($rose(aresetn) |-> &pad_oe_n && !(|pull_up_en))
		else $error("pads not idle after reset");
	write_resp_a: assert property (tk |=> s_axi_bvalid)
		else $error("write answer late");
	resp_drop_a: assert property (s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid)
		else $error("write answer not released");

	cover property (vq_r && m_r[10]);
	cover property (vq_r && m_r[19]);
	cover property (s_axi_bvalid && s_axi_bresp == PFS_RESP_ERR);
endmodule

bind pfs_top pfs_top_chk u_chk (
	.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .pad_out, .pad_oe_n, .gpio_out, .alt1_out,
	.alt2_out, .pull_up_en, .pull_down_en
);
`default_nettype wire

/* File: pfs_top_tb.sv */
// pfs_top_tb: register and pad steering tests through the register bus.
// assumes pfs_top with the checker bound in, one 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module pfs_top_tb
	import pfs_pkg::*;
;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [51:0] pad_in, pad_out, pad_oe_n, gpio_out, gpio_oe_n, gpio_in;
	logic [51:0] alt1_out, alt1_oe_n, alt1_in, alt2_out, alt2_oe_n, alt2_in;
	logic [63:0] pull_up_en, pull_down_en, eu, ed;
	logic [51:0] held;
	logic [3:0] ws = 4'hf;
	int failures, checked, cyc;

	// pads 30-36 leave reset on their first alternate
	localparam logic [51:0] BS = 52'h1f_c000_0000;
	localparam logic [31:0] MX [11] = '{32'h0, 32'h400, 32'h200, 32'h100, 32'h10,
		32'h2, 32'h8_0000, 32'hff47_38ed, 32'h10_8000, 32'h20_4000, 32'h30_c000};
	localparam logic [51:0] S1 [11] = '{BS, BS | 52'hff, BS | 52'h3f00, BS | 52'hc000,
		BS | 52'h3fff_0000, 52'h18_0000_0000, 52'h7_c000_0000, 52'hf_fbbf_c000_0000,
		BS | 52'h40_0000_0000, BS | 52'h400_0000_0000, BS};
	localparam logic [51:0] S2 [11] = '{52'h0, 52'h0, 52'h0, 52'h0, 52'h0, 52'h0,
		52'h18_0000_0000, 52'h0, 52'h400_0000_0000, 52'h40_0000_0000, 52'h0};
	localparam logic [31:0] PV [4] = '{32'he4e4_e4e4, 32'h0001_0002, 32'h4000_0001,
		32'h9c6c_e4b1};

	pfs_top u_pfs_top (
		.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pad_in, .pad_out, .pad_oe_n, .gpio_out, .gpio_oe_n, .gpio_in,
		.alt1_out, .alt1_oe_n, .alt1_in, .alt2_out, .alt2_oe_n, .alt2_in,
		.pull_up_en, .pull_down_en
	);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic report_and_stop;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// both channels offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= ws;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk({s_axi_rresp, s_axi_rdata}, {er, e});
	endtask

	function automatic logic [51:0] pk(input logic [51:0] g, a, b, s1, s2);
		return g & ~s1 & ~s2 | a & s1 | b & s2;
	endfunction

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 6000) begin
			failures++;
			report_and_stop;
		end
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{pad_in, gpio_out, gpio_oe_n, alt1_out, alt1_oe_n, alt2_out, alt2_oe_n} = '0;
		s_axi_wstrb = 4'h0;
		aresetn = 1'b0;
		ce = 1'b1;
		repeat (5) @(posedge aclk);
		chk(pad_oe_n, {52{1'b1}});
		chk(pull_up_en | pull_down_en, 64'h0);
		aresetn <= 1'b1;
		for (int r = 0; r < 5; r++)
			rd(PFS_OFS_MUX + 8'(4 * r), 32'h0, PFS_RESP_OK);
		// two source patterns so a stuck pad cannot pass by luck
		for (int p = 0; p < 2; p++) begin
			gpio_out <= {52{p[0]}};
			gpio_oe_n <= {52{~p[0]}};
			alt1_out <= {52{~p[0]}};
			alt1_oe_n <= {52{p[0]}};
			alt2_out <= {52{p[0]}};
			alt2_oe_n <= {52{p[0]}};
			pad_in <= {13{p[0] ? 4'h5 : 4'ha}};
			for (int i = 0; i < 11; i++) begin
				wr(PFS_OFS_MUX, MX[i], PFS_RESP_OK);
				rd(PFS_OFS_MUX, MX[i] & PFS_MUX_WMASK, PFS_RESP_OK);
				repeat (4) @(posedge aclk);
				chk(pad_out, pk(gpio_out, alt1_out, alt2_out, S1[i], S2[i]));
				chk(pad_oe_n, pk(gpio_oe_n, alt1_oe_n, alt2_oe_n, S1[i], S2[i]));
				chk(gpio_in, pk(pad_in, '0, '0, S1[i], S2[i]));
				chk(alt1_in, pk('0, pad_in, '0, S1[i], S2[i]));
				chk(alt2_in, pk('0, '0, pad_in, S1[i], S2[i]));
			end
		end
		for (int r = 0; r < 4; r++)
			wr(PFS_OFS_P0AB + 8'(4 * r), PV[r], PFS_RESP_OK);
		for (int r = 0; r < 4; r++) begin
			rd(PFS_OFS_P0AB + 8'(4 * r), PV[r], PFS_RESP_OK);
			for (int i = 0; i < 16; i++) begin
				eu[16 * r + i] = PV[r][2 * i +: 2] == PFS_PULL_UP;
				ed[16 * r + i] = PV[r][2 * i +: 2] == PFS_PULL_DN;
			end
		end
		chk(pull_up_en, eu);
		chk(pull_down_en, ed);
		// enable low: pads keep their level although the gpio side flips
		held = pad_out;
		ce <= 1'b0;
		gpio_out <= ~gpio_out;
		repeat (3) @(posedge aclk);
		chk(pad_out, held);
		ce <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(pad_out, pk(gpio_out, alt1_out, alt2_out, S1[10], S2[10]));
		wr(8'h38, 32'hffff_ffff, PFS_RESP_ERR);
		rd(8'h3c, 32'h0, PFS_RESP_ERR);
		rd(8'h20, 32'h0, PFS_RESP_ERR);
		rd(PFS_OFS_P1CD, PV[3], PFS_RESP_OK);
		// only byte lane 1 written, the other lanes keep their pulls
		ws = 4'h2;
		wr(PFS_OFS_P1CD, 32'h0, PFS_RESP_OK);
		ws = 4'hf;
		rd(PFS_OFS_P1CD, 32'h9c6c_00b1, PFS_RESP_OK);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(pull_up_en | pull_down_en, 64'h0);
		aresetn <= 1'b1;
		rd(PFS_OFS_P1CD, 32'h0, PFS_RESP_OK);
		report_and_stop;
	end
endmodule
`default_nettype wire
